// ==== core/csd_defs.vh ====
`ifndef CSD_DEFS_VH
`define CSD_DEFS_VH

// ==========================================================
// Register offsets (4-bit address, 8-bit data)
`define CSD_ADDR_W             4
`define CSD_DATA_W             8
`define CSD_OFS_SCAN_CONFIG    4'h0
`define CSD_OFS_SCAN_STATUS    4'h1
`define CSD_OFS_CHANNEL_INPUT  4'h2
`define CSD_OFS_SHORT_THLD     4'h3
`define CSD_OFS_AUX_CONTROL    4'h4
`define CSD_OFS_DIAG_FLAGS     4'h5

// ==========================================================
// Scan configuration fields
`define CSD_SCAN_START_LSB     0
`define CSD_SCAN_START_MSB     2
`define CSD_SCAN_END_LSB       3
`define CSD_SCAN_END_MSB       5
`define CSD_SCAN_MODE_LSB      6
`define CSD_SCAN_MODE_MSB      7

// ==========================================================
// Scan modes
`define CSD_MODE_SINGLE_CONT   2'h0
`define CSD_MODE_MULTI_SINGLE  2'h1
`define CSD_MODE_MULTI_REPEAT  2'h2
`define CSD_MODE_MULTI_INJECT  2'h3

// ==========================================================
// Scan status fields
`define CSD_STAT_PENDING_BIT   0
`define CSD_STAT_STANDBY_BIT   1
`define CSD_STAT_CHAN_LSB      2
`define CSD_STAT_CHAN_MSB      4
`define CSD_STAT_MODE_LSB      5
`define CSD_STAT_MODE_MSB      6

// ==========================================================
// Diagnostic flag fields
`define CSD_DIAG_SHORT_BIT     0
`define CSD_DIAG_RAIL_BIT      1
`define CSD_DIAG_POR_BIT       2
`define CSD_DIAG_OFLO_LSB      3
`define CSD_DIAG_OFLO_MSB      4
`define CSD_DIAG_TAG_LSB       5
`define CSD_DIAG_TAG_MSB       7

// ==========================================================
// Overrange codes
`define CSD_OFLO_NORMAL        2'h0
`define CSD_OFLO_SOFT          2'h1
`define CSD_OFLO_POS           2'h2
`define CSD_OFLO_NEG           2'h3

// ==========================================================
// Sizes and reset values
`define CSD_NUM_CH             7
`define CSD_CH_W               3
`define CSD_RES_W              16
`define CSD_EXC_W              4
`define CSD_EXC_MAX            4'hA
`define CSD_RST_SCAN_CONFIG    8'h00
`define CSD_RST_CHANNEL_INPUT  7'h00
`define CSD_RST_SHORT_THLD     8'h00
`define CSD_RST_AUX_CONTROL    4'h0

`endif

// ==== core/csd_sync.v ====
`timescale 1ns/1ps

// ==========================================================
// Three-stage pin synchroniser; output moves once stages 2 and 3 agree
module csd_sync (
    // Clock and reset
    input  wire core_clk_i,
    input  wire rst_i,
    // Pin side
    input  wire async_i,
    // Core side
    output reg  sync_o
);

    reg stage1;
    reg stage2;
    reg stage3;

    always @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            stage1 <= 1'b0;
            stage2 <= 1'b0;
            stage3 <= 1'b0;
            sync_o <= 1'b0;
        end else begin
            stage1 <= async_i;
            stage2 <= stage1;
            stage3 <= stage2;
            if (stage2 == stage3) begin
                sync_o <= stage3;
            end
        end
    end

endmodule // csd_sync

// ==== core/csd_scan_diag.v ====
// Notes on behaviour
// - Four scan modes select scanning between start and end channel of one register.
// - Scan config writes sit in a shadow copy, moved to active at conversion start.
// - Further writes ignored while shadow is pending; a status bit shows pending.
// - Single-channel continuous mode converts only the start channel, forever.
// - Single-pass mode converts start to end once, then goes to standby.
// - Repeat mode converts start to end, then restarts at start, forever.
// - Injection mode sequences as repeat mode, injecting only after conversion ends.
// - Burnout drive exists in every mode, gated per channel by its enable bit.
// - Modes 0 to 2 inject into every enabled channel; software enables one only.
// - Injection mode drives burnout into the most recently sampled channel only.
// - Short flag set when result magnitude is within the threshold register value.
// - Near-rail flag follows the sampled channel being within 50mV of a rail.
// - Power-on flag set by reset, cleared by reading the flag register.
// - Overrange code: 0 normal, 1 soft overrange, 2 positive, 3 negative.
// - Channel tag names the previously converted channel whose results are shown.
// - Excitation select takes 11 codes, 0 to 10, in 100 microamp steps; writes above 10 are ignored.
`include "csd_defs.vh"
`timescale 1ns/1ps

module csd_scan_diag (
    // Clock and reset
    input  wire                        core_clk_i,
    input  wire                        rst_i,
    // Register port
    input  wire [`CSD_ADDR_W-1:0]      reg_addr_i,
    input  wire [`CSD_DATA_W-1:0]      reg_wdata_i,
    input  wire                        reg_wr_i,
    input  wire                        reg_rd_i,
    output reg  [`CSD_DATA_W-1:0]      reg_rdata_o,
    // Converter handshake
    input  wire                        conv_start_i,
    input  wire                        conv_done_i,
    input  wire [`CSD_RES_W-1:0]       conv_result_i,
    input  wire                        over_soft_i,
    input  wire                        over_pos_i,
    input  wire                        over_neg_i,
    // Analog comparator pin
    input  wire                        near_rail_i,
    // Sequencer outputs
    output reg                         conv_enable_o,
    output reg  [`CSD_CH_W-1:0]        conv_channel_o,
    output reg  [`CSD_NUM_CH-1:0]      burnout_o,
    output reg  [`CSD_EXC_W-1:0]       excitation_current_select_o
);

    // ==========================================================
    // Channel decode
    function [`CSD_NUM_CH-1:0] chan_onehot;
        input [`CSD_CH_W-1:0] ch;
        integer k;
        begin
            chan_onehot = {`CSD_NUM_CH{1'b0}};
            for (k = 0; k < `CSD_NUM_CH; k = k + 1) begin
                if (ch == k[`CSD_CH_W-1:0]) begin
                    chan_onehot[k] = 1'b1;
                end
            end
        end
    endfunction

    // ==========================================================
    // State
    reg  [`CSD_DATA_W-1:0]   scan_shadow;
    reg  [`CSD_DATA_W-1:0]   scan_config_reg;
    reg                      scan_update_pending;
    reg                      standby;
    reg  [`CSD_NUM_CH-1:0]   channel_input_config;
    reg  [`CSD_DATA_W-1:0]   short_threshold_reg;
    reg  [`CSD_EXC_W-1:0]    excitation_current_select;
    reg                      short_detect_flag;
    reg                      near_rail_flag;
    reg                      power_on_since_read_flag;
    reg  [1:0]               overrange_code;
    reg  [`CSD_CH_W-1:0]     result_channel_tag;
    reg  [`CSD_CH_W-1:0]     cur_channel;
    wire                     near_rail_sync;

    wire [1:0]            scan_mode_select;
    wire [`CSD_CH_W-1:0]  scan_start_channel;
    wire [`CSD_CH_W-1:0]  scan_end_channel;

    assign scan_mode_select   = scan_config_reg[`CSD_SCAN_MODE_MSB:`CSD_SCAN_MODE_LSB];
    assign scan_start_channel = scan_config_reg[`CSD_SCAN_START_MSB:`CSD_SCAN_START_LSB];
    assign scan_end_channel   = scan_config_reg[`CSD_SCAN_END_MSB:`CSD_SCAN_END_LSB];

    wire wr_scan;
    wire wr_chan;
    wire wr_thld;
    wire wr_aux;
    wire rd_diag;

    assign wr_scan = reg_wr_i && (reg_addr_i == `CSD_OFS_SCAN_CONFIG);
    assign wr_chan = reg_wr_i && (reg_addr_i == `CSD_OFS_CHANNEL_INPUT);
    assign wr_thld = reg_wr_i && (reg_addr_i == `CSD_OFS_SHORT_THLD);
    assign wr_aux  = reg_wr_i && (reg_addr_i == `CSD_OFS_AUX_CONTROL);
    assign rd_diag = reg_rd_i && (reg_addr_i == `CSD_OFS_DIAG_FLAGS);

    // ==========================================================
    // Near-rail comparator arrives from the analog side
    csd_sync u_rail_sync (
        .core_clk_i (core_clk_i),
        .rst_i      (rst_i),
        .async_i    (near_rail_i),
        .sync_o     (near_rail_sync)
    );

    // ==========================================================
    // Plain configuration registers
    always @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            channel_input_config      <= `CSD_RST_CHANNEL_INPUT;
            short_threshold_reg       <= `CSD_RST_SHORT_THLD;
            excitation_current_select <= `CSD_RST_AUX_CONTROL;
        end else begin
            if (wr_chan) begin
                channel_input_config <= reg_wdata_i[`CSD_NUM_CH-1:0];
            end
            if (wr_thld) begin
                short_threshold_reg <= reg_wdata_i;
            end
            // Codes above the top step would ask for more current than exists
            if (wr_aux && (reg_wdata_i[`CSD_EXC_W-1:0] <= `CSD_EXC_MAX)) begin
                excitation_current_select <= reg_wdata_i[`CSD_EXC_W-1:0];
            end
        end
    end

    // ==========================================================
    // Double-buffered scan configuration and sequencer
    reg [`CSD_CH_W-1:0] next_channel;
    reg                 next_standby;

    always @* begin
        next_channel = cur_channel;
        next_standby = standby;
        case (scan_mode_select)
            `CSD_MODE_SINGLE_CONT: begin
                next_channel = scan_start_channel;
            end
            `CSD_MODE_MULTI_SINGLE: begin
                if (cur_channel >= scan_end_channel) begin
                    next_standby = 1'b1;
                end else begin
                    next_channel = cur_channel + 3'h1;
                end
            end
            `CSD_MODE_MULTI_REPEAT,
            `CSD_MODE_MULTI_INJECT: begin
                // A reversed range behaves as a one-channel loop on the start channel
                if (cur_channel >= scan_end_channel) begin
                    next_channel = scan_start_channel;
                end else begin
                    next_channel = cur_channel + 3'h1;
                end
            end
            default: begin
                next_channel = scan_start_channel;
            end
        endcase
    end

    always @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            scan_shadow         <= `CSD_RST_SCAN_CONFIG;
            scan_config_reg     <= `CSD_RST_SCAN_CONFIG;
            scan_update_pending <= 1'b0;
            standby             <= 1'b0;
            cur_channel         <= {`CSD_CH_W{1'b0}};
        end else begin
            if (conv_start_i && scan_update_pending) begin
                scan_config_reg     <= scan_shadow;
                scan_update_pending <= 1'b0;
                standby             <= 1'b0;
                cur_channel         <= scan_shadow[`CSD_SCAN_START_MSB:`CSD_SCAN_START_LSB];
            end else begin
                if (wr_scan && !scan_update_pending) begin
                    scan_shadow         <= reg_wdata_i;
                    scan_update_pending <= 1'b1;
                end
                if (conv_done_i && !standby) begin
                    cur_channel <= next_channel;
                    standby     <= next_standby;
                end
            end
        end
    end

    // ==========================================================
    // Diagnostic flags, latched with each finished conversion
    wire [`CSD_RES_W-1:0] res_mag;

    // Full-scale negative maps to 0x8000, correct as an unsigned magnitude
    assign res_mag = conv_result_i[`CSD_RES_W-1] ? (~conv_result_i + 16'h0001) : conv_result_i;

    always @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            short_detect_flag  <= 1'b0;
            near_rail_flag     <= 1'b0;
            overrange_code     <= `CSD_OFLO_NORMAL;
            result_channel_tag <= {`CSD_CH_W{1'b0}};
        end else if (conv_done_i && !standby) begin
            // Threshold scaling equals result code units, so codes compare directly
            short_detect_flag  <= (res_mag <= {8'h00, short_threshold_reg});
            near_rail_flag     <= near_rail_sync;
            result_channel_tag <= cur_channel;
            if (over_pos_i) begin
                overrange_code <= `CSD_OFLO_POS;
            end else if (over_neg_i) begin
                overrange_code <= `CSD_OFLO_NEG;
            end else if (over_soft_i) begin
                overrange_code <= `CSD_OFLO_SOFT;
            end else begin
                overrange_code <= `CSD_OFLO_NORMAL;
            end
        end
    end

    // Reset is the power-on event; it forces the flag high even mid-read
    always @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            power_on_since_read_flag <= 1'b1;
        end else if (rd_diag) begin
            power_on_since_read_flag <= 1'b0;
        end
    end

    // ==========================================================
    // Burnout and sequencer outputs
    reg [`CSD_NUM_CH-1:0] next_burnout;

    always @* begin
        next_burnout = {`CSD_NUM_CH{1'b0}};
        if (scan_mode_select == `CSD_MODE_MULTI_INJECT) begin
            // Last sampled channel only, so the live conversion stays clean
            next_burnout = chan_onehot(result_channel_tag) & channel_input_config;
        end else begin
            next_burnout = channel_input_config;
        end
    end

    always @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            burnout_o                   <= {`CSD_NUM_CH{1'b0}};
            conv_enable_o               <= 1'b0;
            conv_channel_o              <= {`CSD_CH_W{1'b0}};
            excitation_current_select_o <= `CSD_RST_AUX_CONTROL;
        end else begin
            burnout_o                   <= next_burnout;
            conv_enable_o               <= !standby;
            conv_channel_o              <= cur_channel;
            excitation_current_select_o <= excitation_current_select;
        end
    end

    // ==========================================================
    // Read port, data valid the cycle after the strobe
    reg [`CSD_DATA_W-1:0] next_rdata;

    always @* begin
        next_rdata = {`CSD_DATA_W{1'b0}};
        case (reg_addr_i)
            `CSD_OFS_SCAN_CONFIG: begin
                next_rdata = scan_shadow;
            end
            `CSD_OFS_SCAN_STATUS: begin
                next_rdata[`CSD_STAT_PENDING_BIT] = scan_update_pending;
                next_rdata[`CSD_STAT_STANDBY_BIT] = standby;
                next_rdata[`CSD_STAT_CHAN_MSB:`CSD_STAT_CHAN_LSB] = cur_channel;
                next_rdata[`CSD_STAT_MODE_MSB:`CSD_STAT_MODE_LSB] = scan_mode_select;
            end
            `CSD_OFS_CHANNEL_INPUT: begin
                next_rdata[`CSD_NUM_CH-1:0] = channel_input_config;
            end
            `CSD_OFS_SHORT_THLD: begin
                next_rdata = short_threshold_reg;
            end
            `CSD_OFS_AUX_CONTROL: begin
                next_rdata[`CSD_EXC_W-1:0] = excitation_current_select;
            end
            `CSD_OFS_DIAG_FLAGS: begin
                next_rdata[`CSD_DIAG_SHORT_BIT] = short_detect_flag;
                next_rdata[`CSD_DIAG_RAIL_BIT]  = near_rail_flag;
                next_rdata[`CSD_DIAG_POR_BIT]   = power_on_since_read_flag;
                next_rdata[`CSD_DIAG_OFLO_MSB:`CSD_DIAG_OFLO_LSB] = overrange_code;
                next_rdata[`CSD_DIAG_TAG_MSB:`CSD_DIAG_TAG_LSB]   = result_channel_tag;
            end
            default: begin
                next_rdata = {`CSD_DATA_W{1'b0}};
            end
        endcase
    end

    always @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            reg_rdata_o <= {`CSD_DATA_W{1'b0}};
        end else if (reg_rd_i) begin
            reg_rdata_o <= next_rdata;
        end else begin
            reg_rdata_o <= {`CSD_DATA_W{1'b0}};
        end
    end

endmodule // csd_scan_diag

// ==== test/csd_scan_diag_sva.sv ====
`timescale 1ns/1ps
`include "csd_defs.vh"

module csd_scan_diag_sva (
    // Clock and reset
    input wire                   core_clk_i,
    input wire                   rst_i,
    // Register port
    input wire [`CSD_ADDR_W-1:0] reg_addr_i,
    input wire                   reg_wr_i,
    input wire                   reg_rd_i,
    input wire [`CSD_DATA_W-1:0] reg_rdata_o,
    // Converter and sequencer
    input wire                   conv_start_i,
    input wire                   conv_done_i,
    input wire                   conv_enable_o,
    input wire [`CSD_CH_W-1:0]   conv_channel_o,
    input wire [`CSD_NUM_CH-1:0] burnout_o,
    input wire [`CSD_EXC_W-1:0]  excitation_current_select_o
);
    // ==========
    // Event history, outputs trail the internal change by one cycle
    reg [1:0] evt_d;
    reg [1:0] wr_d;
    always @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            evt_d <= 2'b00;
            wr_d  <= 2'b00;
        end else begin
            evt_d <= {evt_d[0], conv_start_i | conv_done_i};
            wr_d  <= {wr_d[0], reg_wr_i};
        end
    end

    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (rst_i);

    // ==========
    // Properties
    pending_bit_a: assert property (
        reg_wr_i && reg_addr_i == `CSD_OFS_SCAN_CONFIG && !conv_start_i ##1
        reg_rd_i && reg_addr_i == `CSD_OFS_SCAN_STATUS && !conv_start_i
        |=> reg_rdata_o[`CSD_STAT_PENDING_BIT]) else $error("pending bit not shown");
    standby_hold_a: assert property (
        !conv_enable_o && !conv_start_i && !$past(conv_start_i) && !$past(rst_i)
        |=> !conv_enable_o) else $error("left standby without a transfer");
    standby_entry_a: assert property (
        $fell(conv_enable_o) |-> evt_d[1]) else $error("standby without conversion end");
    burnout_cause_a: assert property (
        $changed(burnout_o) |-> (|evt_d) || (|wr_d)) else $error("burnout moved on its own");
    channel_cause_a: assert property (
        $changed(conv_channel_o) |-> |evt_d) else $error("channel moved without event");
    step_wrap_a: assert property (
        $changed(conv_channel_o) && conv_enable_o && $past(conv_done_i, 2)
        && !$past(conv_start_i, 2) |-> conv_channel_o == $past(conv_channel_o) + 3'd1
        || conv_channel_o < $past(conv_channel_o)) else $error("channel step wrong");
    exc_range_a: assert property (
        excitation_current_select_o <= `CSD_EXC_MAX) else $error("excitation out of range");
    por_clear_a: assert property (
        reg_rd_i && reg_addr_i == `CSD_OFS_DIAG_FLAGS ##2
        reg_rd_i && reg_addr_i == `CSD_OFS_DIAG_FLAGS
        |=> !reg_rdata_o[`CSD_DIAG_POR_BIT]) else $error("power-on flag not cleared");

    standby_c: cover property ($fell(conv_enable_o));
    wake_c: cover property ($rose(conv_enable_o));
    burnout_c: cover property ($changed(burnout_o));
endmodule // csd_scan_diag_sva

bind csd_scan_diag csd_scan_diag_sva csd_scan_diag_sva_i (
    .core_clk_i(core_clk_i), .rst_i(rst_i), .reg_addr_i(reg_addr_i),
    .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
    .conv_start_i(conv_start_i), .conv_done_i(conv_done_i),
    .conv_enable_o(conv_enable_o), .conv_channel_o(conv_channel_o), .burnout_o(burnout_o),
    .excitation_current_select_o(excitation_current_select_o));

// ==== test/tb_top.sv ====
`timescale 1ns/1ps
`include "csd_defs.vh"

module tb_top;
    // ==========
    // Design inputs and outputs
    reg         core_clk_i = 1'b0;
    reg         rst_i = 1'b1;
    reg  [3:0]  reg_addr_i = 4'h0;
    reg  [7:0]  reg_wdata_i = 8'h00;
    reg         reg_wr_i = 1'b0;
    reg         reg_rd_i = 1'b0;
    reg         conv_start_i = 1'b0;
    reg         conv_done_i = 1'b0;
    reg  [15:0] conv_result_i = 16'h0000;
    reg         over_soft_i = 1'b0;
    reg         over_pos_i = 1'b0;
    reg         over_neg_i = 1'b0;
    reg         near_rail_i = 1'b0;
    wire [7:0]  reg_rdata_o;
    wire        conv_enable_o;
    wire [2:0]  conv_channel_o;
    wire [6:0]  burnout_o;
    wire [3:0]  excitation_current_select_o;
    int         bad_count = 0;
    int         num_checks = 0;
    int         cyc = 0;
    logic [1:0] j;
    // Rows are {write, address, data}; for reads data is the expected value
    logic [12:0] rows [15] = '{13'h0504, 13'h0500, 13'h0000, 13'h0200, 13'h13DA,
        13'h03DA, 13'h140A, 13'h040A, 13'h140B, 13'h040A, 13'h1201, 13'h0201,
        13'h11FF, 13'h0100, 13'h0900};

    always #12.5 core_clk_i = ~core_clk_i;

    csd_scan_diag csd_scan_diag_i (
        .core_clk_i(core_clk_i), .rst_i(rst_i), .reg_addr_i(reg_addr_i),
        .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
        .reg_rdata_o(reg_rdata_o), .conv_start_i(conv_start_i), .conv_done_i(conv_done_i),
        .conv_result_i(conv_result_i), .over_soft_i(over_soft_i), .over_pos_i(over_pos_i),
        .over_neg_i(over_neg_i), .near_rail_i(near_rail_i), .conv_enable_o(conv_enable_o),
        .conv_channel_o(conv_channel_o), .burnout_o(burnout_o),
        .excitation_current_select_o(excitation_current_select_o));

    // ==========
    // Checking and bus tasks
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
        num_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD %s expected %h seen %h", nm, exp, got);
        end
    endtask

    // A write leaves its strobe up; the next task lowers it
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge core_clk_i);
        reg_wr_i <= 1'b1;
        reg_addr_i <= a;
        reg_wdata_i <= d;
    endtask

    task automatic rd(input logic [3:0] a, input logic [7:0] exp);
        @(posedge core_clk_i);
        reg_wr_i <= 1'b0;
        reg_rd_i <= 1'b1;
        reg_addr_i <= a;
        @(posedge core_clk_i);
        reg_rd_i <= 1'b0;
        @(negedge core_clk_i);
        chk("read data", exp, reg_rdata_o);
    endtask

    task automatic ev(input logic s, input logic d, input logic [15:0] r, input logic [2:0] ov);
        @(posedge core_clk_i);
        reg_wr_i <= 1'b0;
        conv_start_i <= s;
        conv_done_i <= d;
        conv_result_i <= r;
        {over_soft_i, over_pos_i, over_neg_i} <= ov;
        @(posedge core_clk_i);
        conv_start_i <= 1'b0;
        conv_done_i <= 1'b0;
        repeat (2) @(posedge core_clk_i);
        #1;
    endtask

    task automatic pins(input logic [2:0] ch, input logic en);
        chk("channel", {5'h00, ch}, {5'h00, conv_channel_o});
        chk("enable", {7'h00, en}, {7'h00, conv_enable_o});
    endtask

    always @(posedge core_clk_i) begin
        cyc++;
        if (cyc == 4000) begin
            bad_count++;
            report_and_stop;
        end
    end

    // ==========
    // Main sequence
    initial begin
        repeat (12) @(posedge core_clk_i);
        rst_i <= 1'b0;
        for (int i = 0; i < 15; i++) begin
            if (rows[i][12]) wr(rows[i][11:8], rows[i][7:0]);
            else rd(rows[i][11:8], rows[i][7:0]);
        end
        chk("excitation", 8'h0A, {4'h0, excitation_current_select_o});
        // Single pass 2..4, second write lost while pending
        wr(4'h0, 8'h62);
        rd(4'h1, 8'h01);
        wr(4'h0, 8'h00);
        rd(4'h0, 8'h62);
        pins(3'd0, 1'b1);
        ev(1'b1, 1'b0, 16'h0000, 3'b000);
        pins(3'd2, 1'b1);
        ev(1'b0, 1'b1, 16'h0010, 3'b000);
        pins(3'd3, 1'b1);
        rd(4'h5, 8'h41);
        ev(1'b0, 1'b1, 16'h0100, 3'b000);
        pins(3'd4, 1'b1);
        ev(1'b0, 1'b1, 16'h0100, 3'b000);
        chk("enable", 8'h00, {7'h00, conv_enable_o});
        ev(1'b0, 1'b1, 16'h0000, 3'b000);
        ev(1'b1, 1'b0, 16'h0000, 3'b000);
        chk("enable", 8'h00, {7'h00, conv_enable_o});
        rd(4'h5, 8'h80);
        // Repeat 0..1 with every overrange code; one burnout enable only
        wr(4'h0, 8'h88);
        ev(1'b1, 1'b0, 16'h0000, 3'b000);
        pins(3'd0, 1'b1);
        chk("burnout", 8'h01, {1'b0, burnout_o});
        for (int i = 0; i < 4; i++) begin
            j = i;
            ev(1'b0, 1'b1, j[0] ? 16'h00DB : 16'hFF26, {j == 2'd1, j == 2'd2, j == 2'd3});
            pins({2'b00, ~j[0]}, 1'b1);
            rd(4'h5, {2'b00, j[0], j, 2'b00, ~j[0]});
        end
        // Injection mode 0..2; two enables only once mode 3 is active
        wr(4'h0, 8'hD0);
        ev(1'b1, 1'b0, 16'h0000, 3'b000);
        wr(4'h2, 8'h05);
        for (int i = 0; i < 3; i++) begin
            ev(1'b0, 1'b1, 16'h1000, 3'b000);
            chk("burnout", i == 1 ? 8'h00 : 8'h01 << i, {1'b0, burnout_o});
        end
        pins(3'd0, 1'b1);
        // Single-channel mode stays on the start channel
        wr(4'h0, 8'h03);
        ev(1'b1, 1'b0, 16'h0000, 3'b000);
        for (int i = 0; i < 2; i++) begin
            ev(1'b0, 1'b1, 16'h1000, 3'b000);
            pins(3'd3, 1'b1);
        end
        // Near-rail comparator through the synchroniser
        near_rail_i <= 1'b1;
        repeat (6) @(posedge core_clk_i);
        ev(1'b0, 1'b1, 16'h7FFF, 3'b000);
        near_rail_i <= 1'b0;
        rd(4'h5, 8'h62);
        // Second power-on reset in mid-run
        rst_i <= 1'b1;
        repeat (3) @(posedge core_clk_i);
        rst_i <= 1'b0;
        rd(4'h5, 8'h04);
        pins(3'd0, 1'b1);
        report_and_stop;
    end
endmodule // tb_top
